// *** rtl/codec_regs_defines.svh ***
/*
  Register offsets, field positions, reset values and decode constants for the audio format
  and headset input gain/AGC register bank.
  Assumes it is included by bare name from the register bank module.
*/
// Summary of operation
// R1: The two-bit high-pass field disables the ADC filter at 00 and sets the corner at 0.0045, 0.0125 or 0.025 Fs.
// R2: The two-bit word-size field selects 16, 20, 24 or 32 bit serial words and resets to 00.
// R3: The serial format field selects I2S, DSP, right- or left-justified; right-justified needs an integer rate ratio.
// R4: The three-bit playback rate field divides the reference rate by 1, 1.5, 2, 3, 4, 5, 5.5 or 6.
// R5: The three-bit record rate field uses the same divisor encoding and resets to 000.
// R6: The headset input mute bit mutes the input when set and resets to one.
// R7: The seven-bit headset gain field sets 0 to 59.5 dB in 0.5 dB steps and resets to all ones.
// R8: With the AGC on and the headset input selected, the mute and gain fields read back the AGC's applied gain.
// R9: The three-bit AGC target field sets the output level from -5.5 dB down to -24 dB.
// R10: The four-bit AGC time field sets attack 8 to 20 ms in its low bits and decay 100 to 500 ms in its high bits.
// R11: The AGC enable bit hands PGA control to the AGC when set, otherwise software fields rule; it resets to zero. The code also needs headset_selected.
// R12: Reserved bits of the audio control register read as zero and writes to them do nothing.
`ifndef CODEC_REGS_DEFINES_SVH
`define CODEC_REGS_DEFINES_SVH

`define FMT_REG_ADDR 12'h000
`define GAIN_REG_ADDR 12'h004
`define FMT_REG_INDEX 4'h0
`define GAIN_REG_INDEX 4'h1

`define FMT_WRITE_MASK 16'hCF3F
`define FMT_RESET 16'h0000
`define GAIN_RESET 16'hFF00

`define HPF_MSB 15
`define HPF_LSB 14
`define WSIZE_MSB 11
`define WSIZE_LSB 10
`define SFMT_MSB 9
`define SFMT_LSB 8
`define PRATE_MSB 5
`define PRATE_LSB 3
`define RRATE_MSB 2
`define RRATE_LSB 0

`define MUTE_BIT 15
`define PGA_MSB 14
`define PGA_LSB 8
`define TGT_MSB 7
`define TGT_LSB 5
`define TC_MSB 4
`define TC_LSB 1
`define AGCEN_BIT 0

`define PGA_MAX_CODE 7'h77
`define HPF_CORNER_0_PPM 20'h0_1194
`define HPF_CORNER_1_PPM 20'h0_30D4
`define HPF_CORNER_2_PPM 20'h0_61A8

`endif

// *** rtl/codec_regs_pkg.sv ***
/*
  Types shared by the register bank and its decode helper.
  Assumes the defines header is on the include path.
*/
`default_nettype none
package codec_regs_pkg;
  typedef enum logic [1:0] {SFMT_I2S, SFMT_DSP, SFMT_RIGHT, SFMT_LEFT} serial_format_t;
  typedef enum logic [1:0] {APB_IDLE, APB_ACCESS} apb_state_t;
  // Divisor held as twice its value so half steps stay integral.
  function automatic logic [3:0] rate_divisor_x2(input logic [2:0] code);
    case (code)
      3'h0: rate_divisor_x2 = 4'h2;
      3'h1: rate_divisor_x2 = 4'h3;
      3'h2: rate_divisor_x2 = 4'h4;
      3'h3: rate_divisor_x2 = 4'h6;
      3'h4: rate_divisor_x2 = 4'h8;
      3'h5: rate_divisor_x2 = 4'hA;
      3'h6: rate_divisor_x2 = 4'hB;
      default: rate_divisor_x2 = 4'hC;
    endcase
  endfunction : rate_divisor_x2
endpackage : codec_regs_pkg
`default_nettype wire

// *** rtl/rate_decode.sv ***
/*
  Decodes a three-bit rate code into a doubled reference-rate divisor.
  Assumes a stable code from a register; purely combinational.
*/
`default_nettype none
module rate_decode
  import codec_regs_pkg::*;
(
  input wire logic [2:0] code,     // Rate code.
  output logic [3:0] divisor_x2    // Divisor times two.
);
  // Shared encoding for playback and record paths.
  assign divisor_x2 = rate_divisor_x2(code); // see R4 see R5
endmodule : rate_decode
`default_nettype wire

// *** rtl/agc_time_decode.sv ***
/*
  Decodes the AGC time-constant field into attack and decay times in milliseconds.
  Assumes a stable four-bit code; purely combinational.
*/
`default_nettype none
module agc_time_decode (
  input wire logic [3:0] code,      // Time-constant code.
  output logic [4:0] attack_ms,     // Attack time in ms.
  output logic [9:0] decay_ms       // Decay time in ms.
);
  // Low pair picks attack, high pair picks decay; sample rate plays no part.
  assign attack_ms = (code[1:0] == 2'h0) ? 5'h08 : (code[1:0] == 2'h1) ? 5'h0B :
                     (code[1:0] == 2'h2) ? 5'h10 : 5'h14; // see R10
  assign decay_ms = (code[3:2] == 2'h0) ? 10'h064 : (code[3:2] == 2'h1) ? 10'h0C8 :
                    (code[3:2] == 2'h2) ? 10'h190 : 10'h1F4; // see R10
endmodule : agc_time_decode
`default_nettype wire

// *** rtl/audio_codec_format_agc_regs.sv ***
/*
  APB register bank for the audio format/rate control and headset input gain/AGC registers.
  Decodes each field into configuration outputs for the serial port, rate generator, ADC filter,
  and headset PGA. Assumes the AGC core supplies its applied gain and that the analog input
  selection reports when the headset input is routed to the ADC.
*/
`default_nettype none
`include "codec_regs_defines.svh"
module audio_codec_format_agc_regs
  import codec_regs_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic pclk,                      // APB clock, 10 MHz.
  input wire logic presetn,                   // Asynchronous active-low reset.
  input wire logic psel,                      // APB select.
  input wire logic penable,                   // APB access phase.
  input wire logic pwrite,                    // APB write direction.
  input wire logic [ADDR_WIDTH-1:0] paddr,    // APB byte address.
  input wire logic [31:0] pwdata,             // APB write data.
  input wire logic [3:0] pstrb,               // APB byte strobes.
  output logic [31:0] prdata,                 // APB read data.
  output logic pready,                        // APB ready.
  output logic pslverr,                       // APB error for unmapped address.
  input wire logic headset_selected,          // Headset input routed to the ADC.
  input wire logic [7:0] agc_applied_gain,    // AGC gain, mute bit plus seven gain bits.
  output logic hpf_enable,                    // ADC high-pass filter on.
  output logic [19:0] hpf_corner_ppm,         // Corner as millionths of Fs.
  output logic [5:0] word_size_bits,          // Serial word size in bits.
  output serial_format_t serial_format_select,// Serial data format.
  output logic format_invalid,                // Right-justified with non-integer ratio.
  output logic [3:0] playback_divisor_x2,     // Playback divisor times two.
  output logic [3:0] record_divisor_x2,       // Record divisor times two.
  output logic headset_pga_mute,              // Mute applied to the headset PGA.
  output logic [6:0] headset_pga_gain,        // Software gain to PGA, 0.5 dB steps.
  output logic agc_active,                    // AGC owns the PGA.
  output logic [2:0] headset_agc_target,      // AGC target level code.
  output logic [4:0] agc_attack_ms,           // Attack time in ms.
  output logic [9:0] agc_decay_ms             // Decay time in ms.
);

  // Refuse an address bus too narrow to tell the two registers apart.
  if (ADDR_WIDTH < 3) begin : g_addr_width_check
    $error("ADDR_WIDTH too small for the register map.");
  end

  logic [15:0] fmt_ff;
  logic [15:0] gain_ff;
  logic [15:0] nxt_fmt;
  logic [15:0] nxt_gain;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pslverr_ff;
  logic nxt_pslverr;

  // Address decode; only the low 12 address bits matter for the map.
  wire logic [11:0] addr12 = 12'(paddr);
  wire logic hit_fmt = (addr12 == `FMT_REG_ADDR);
  wire logic hit_gain = (addr12 == `GAIN_REG_ADDR);
  wire logic mapped = hit_fmt | hit_gain;
  wire logic setup = psel & ~penable;
  // Writes commit at the access edge, the one at which the master sees pready high.
  wire logic access = psel & penable & pready;
  wire logic wr_fmt = access & pwrite & hit_fmt;
  wire logic wr_gain = access & pwrite & hit_gain;

  // Byte-lane merge; strobes above the 16-bit register width are ignored.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] st);
    merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : merge

  // Reserved bits are masked so they neither store nor read back.
  assign nxt_fmt = wr_fmt ? (merge(fmt_ff, pwdata[15:0], pstrb[1:0]) & `FMT_WRITE_MASK) : fmt_ff; // see R12
  assign nxt_gain = wr_gain ? merge(gain_ff, pwdata[15:0], pstrb[1:0]) : gain_ff;

  // AGC ownership of the PGA needs both the enable and the headset route.
  wire logic agc_owns = gain_ff[`AGCEN_BIT] & headset_selected; // see R11
  wire logic [15:0] gain_readback = agc_owns ? {agc_applied_gain, gain_ff[7:0]} : gain_ff; // see R8

  // Read data is latched during setup so the access phase answers with no wait state.
  assign nxt_prdata = (setup & ~pwrite & hit_fmt) ? {16'h0000, fmt_ff & `FMT_WRITE_MASK} : // see R12
                      (setup & ~pwrite & hit_gain) ? {16'h0000, gain_readback} :
                      setup ? 32'h0000_0000 : prdata_ff;
  assign nxt_pslverr = setup ? ~mapped : pslverr_ff;

  // Register storage; reset values put the headset input muted at full gain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_ff <= `FMT_RESET; // see R2 see R5
      gain_ff <= `GAIN_RESET; // see R6 see R7 see R11
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      fmt_ff <= nxt_fmt;
      gain_ff <= nxt_gain;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // The bank never stalls, so every access phase lasts exactly one cycle.
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff & psel & penable;

  // High-pass filter corner decode; code zero bypasses the filter.
  wire logic [1:0] hpf_code = fmt_ff[`HPF_MSB:`HPF_LSB];
  assign hpf_enable = (hpf_code != 2'h0); // see R1
  assign hpf_corner_ppm = (hpf_code == 2'h1) ? `HPF_CORNER_0_PPM :
                          (hpf_code == 2'h2) ? `HPF_CORNER_1_PPM :
                          (hpf_code == 2'h3) ? `HPF_CORNER_2_PPM : 20'h0_0000; // see R1

  // Word size decode.
  wire logic [1:0] wsize_code = fmt_ff[`WSIZE_MSB:`WSIZE_LSB];
  assign word_size_bits = (wsize_code == 2'h0) ? 6'h10 : (wsize_code == 2'h1) ? 6'h14 :
                          (wsize_code == 2'h2) ? 6'h18 : 6'h20; // see R2

  // Serial format, with a flag when right-justified meets a non-integer rate ratio.
  assign serial_format_select = serial_format_t'(fmt_ff[`SFMT_MSB:`SFMT_LSB]); // see R3
  wire logic [7:0] cross_a = 8'(playback_divisor_x2) * 8'(record_divisor_x2);
  wire logic ratio_integer = ((playback_divisor_x2 % record_divisor_x2) == 4'h0) ||
                             ((record_divisor_x2 % playback_divisor_x2) == 4'h0);
  assign format_invalid = (serial_format_select == SFMT_RIGHT) & ~ratio_integer & (cross_a != 8'h00); // see R3

  // Rate decoders share one encoding.
  rate_decode u_playback_rate (
    .code(fmt_ff[`PRATE_MSB:`PRATE_LSB]),
    .divisor_x2(playback_divisor_x2)
  );
  rate_decode u_record_rate (
    .code(fmt_ff[`RRATE_MSB:`RRATE_LSB]),
    .divisor_x2(record_divisor_x2)
  );

  // PGA control: software mute and gain always drive the PGA outputs; agc_active flags when the AGC owns the stage.
  assign agc_active = agc_owns; // see R11
  assign headset_pga_mute = gain_ff[`MUTE_BIT]; // see R6
  assign headset_pga_gain = (gain_ff[`PGA_MSB:`PGA_LSB] > `PGA_MAX_CODE) ? `PGA_MAX_CODE :
                            gain_ff[`PGA_MSB:`PGA_LSB]; // see R7
  assign headset_agc_target = gain_ff[`TGT_MSB:`TGT_LSB]; // see R9

  // Time constants decoded once for the AGC core.
  agc_time_decode u_agc_time (
    .code(gain_ff[`TC_MSB:`TC_LSB]),
    .attack_ms(agc_attack_ms),
    .decay_ms(agc_decay_ms)
  );

endmodule : audio_codec_format_agc_regs
`default_nettype wire

// *** bench/audio_codec_format_agc_regs_asserts.sv ***
/* Concurrent checks on the register bank's ports.
   Assumes it is bound into every instance of the register bank. */
`default_nettype none
module audio_codec_format_agc_regs_asserts
  import codec_regs_pkg::*;
#(parameter int ADDR_WIDTH = 12) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Access.
  input wire logic pwrite, // Direction.
  input wire logic [ADDR_WIDTH-1:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [3:0] pstrb, // Strobes.
  input wire logic [31:0] prdata, // Read data.
  input wire logic [7:0] agc_applied_gain, // AGC gain.
  input wire logic hpf_enable, // Filter on.
  input wire logic [19:0] hpf_corner_ppm, // Corner.
  input wire logic [5:0] word_size_bits, // Word size.
  input wire serial_format_t serial_format_select, // Format.
  input wire logic format_invalid, // Bad format.
  input wire logic [3:0] playback_divisor_x2, // Divisor.
  input wire logic [3:0] record_divisor_x2, // Divisor.
  input wire logic headset_pga_mute, // Mute.
  input wire logic [6:0] headset_pga_gain, // Gain.
  input wire logic agc_active, // AGC owns PGA.
  input wire logic [2:0] headset_agc_target, // Target.
  input wire logic headset_selected, // Input routed.
  input wire logic [4:0] agc_attack_ms, // Attack.
  input wire logic [9:0] agc_decay_ms // Decay.
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access cycles commit writes and setup cycles latch read data, so effects show one cycle later.
  sequence fmt_wr; psel && penable && pwrite && paddr == 0 && pstrb[1:0] == 2'b11; endsequence
  sequence gain_wr; psel && penable && pwrite && paddr == 12'h004 && pstrb[1:0] == 2'b11; endsequence
  sequence gain_rd; psel && !penable && !pwrite && paddr == 12'h004 && agc_active; endsequence
  a_hpf_corner_set: assert property (hpf_enable == (hpf_corner_ppm != 0) && hpf_corner_ppm inside
    {20'h0_0000, 20'h0_1194, 20'h0_30D4, 20'h0_61A8}) else $error("Filter corner wrong.");
  a_word_size_write: assert property (fmt_wr |=> word_size_bits ==
    (($past(pwdata[11:10]) == 2'b11) ? 6'h20 : 6'h10 + {$past(pwdata[11:10]), 2'b00}))
    else $error("Word size wrong after write.");
  a_format_invalid_only: assert property (format_invalid |-> serial_format_select == SFMT_RIGHT)
    else $error("Invalid flag outside right-justified.");
  a_rate_codes_legal: assert property (playback_divisor_x2 inside {2, 3, 4, 6, 8, 10, 11, 12} &&
    record_divisor_x2 inside {2, 3, 4, 6, 8, 10, 11, 12}) else $error("Rate divisor illegal.");
  a_mute_write: assert property (gain_wr |=> headset_pga_mute == $past(pwdata[15]))
    else $error("Mute did not follow write.");
  a_pga_gain_clamp: assert property (headset_pga_gain <= 7'h77) else $error("Gain above ceiling.");
  a_agc_target_write: assert property (gain_wr |=> headset_agc_target == $past(pwdata[7:5]))
    else $error("Target did not follow write.");
  a_agc_readback: assert property (gain_rd |=> prdata[15:8] == $past(agc_applied_gain))
    else $error("AGC gain not read back.");
  a_agc_time_legal: assert property (agc_attack_ms inside {8, 11, 16, 20} &&
    agc_decay_ms inside {100, 200, 400, 500}) else $error("Time constant illegal.");
  a_agc_needs_input: assert property (agc_active |-> headset_selected) else $error("AGC active unrouted.");
  a_reserved_zero: assert property (psel && penable && !pwrite && paddr == 0 |->
    prdata[31:16] == 0 && prdata[13:12] == 0 && prdata[7:6] == 0) else $error("Reserved bits read nonzero.");
endmodule : audio_codec_format_agc_regs_asserts
bind audio_codec_format_agc_regs audio_codec_format_agc_regs_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_asserts (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .agc_applied_gain, .hpf_enable,
  .hpf_corner_ppm, .word_size_bits, .serial_format_select, .format_invalid, .playback_divisor_x2,
  .record_divisor_x2, .headset_pga_mute, .headset_pga_gain, .agc_active, .headset_agc_target, .headset_selected,
  .agc_attack_ms,
  .agc_decay_ms);
`default_nettype wire

// *** bench/test_audio_codec_format_agc_regs.sv ***
/* Self-checking bench for the register bank, driving APB transfers.
   Assumes the package and header are compiled first and the checker is bound. */
`default_nettype none
module test_audio_codec_format_agc_regs import codec_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, headset_selected = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r, v;
  logic [3:0] pstrb = 4'hF, playback_divisor_x2, record_divisor_x2;
  logic [7:0] agc_applied_gain = 8'h00;
  logic pready, pslverr, hpf_enable, format_invalid, headset_pga_mute, agc_active, e;
  logic [19:0] hpf_corner_ppm;
  logic [5:0] word_size_bits;
  logic [6:0] headset_pga_gain;
  logic [2:0] headset_agc_target;
  logic [4:0] agc_attack_ms;
  logic [9:0] agc_decay_ms;
  serial_format_t serial_format_select;
  int n_mismatch = 0, checked = 0;
  // Expected decodes, doubled divisors so the half steps stay whole.
  logic [3:0] div_tab [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hB, 4'hC};
  logic [19:0] hpf_tab [4] = '{20'h0_0000, 20'h0_1194, 20'h0_30D4, 20'h0_61A8};
  logic [5:0] ws_tab [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
  logic [4:0] att_tab [4] = '{5'h08, 5'h0B, 5'h10, 5'h14};
  logic [9:0] dec_tab [4] = '{10'h064, 10'h0C8, 10'h190, 10'h1F4};
  audio_codec_format_agc_regs u_audio_codec_format_agc_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .headset_selected, .agc_applied_gain, .hpf_enable,
    .hpf_corner_ppm, .word_size_bits, .serial_format_select, .format_invalid, .playback_divisor_x2,
    .record_divisor_x2, .headset_pga_mute, .headset_pga_gain, .agc_active, .headset_agc_target,
    .agc_attack_ms, .agc_decay_ms);
  always #50 pclk = ~pclk;
  // One APB transfer; an idle cycle follows so no signal is driven twice in a step.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // Main sequence: reset values, every format, AGC target and time code, sixteen gain codes, AGC ownership, unmapped access.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, 12'h000, 32'h0, r, e);
    chk(r, 32'h0000_0000);
    xfer(1'b0, 12'h004, 32'h0, r, e);
    chk(r, 32'h0000_FF00);
    chk(32'(headset_pga_gain), 32'h0000_0077);
    for (int i = 0; i < 8; i++) begin
      v = {16'h0000, i[1:0], 2'b11, i[1:0], i[1:0], 2'b11, i[2:0], 3'(7 - i)};
      xfer(1'b1, 12'h000, v, r, e);
      xfer(1'b0, 12'h000, 32'h0, r, e);
      chk(r, v & 32'h0000_CF3F);
      chk(32'(hpf_corner_ppm), 32'(hpf_tab[i % 4]));
      chk(32'(hpf_enable), 32'(i % 4 != 0));
      chk(32'(word_size_bits), 32'(ws_tab[i % 4]));
      chk(32'(serial_format_select), 32'(i % 4));
      chk(32'(format_invalid), 32'((i % 4 == 2) && (div_tab[i] % div_tab[7 - i] != 0) &&
          (div_tab[7 - i] % div_tab[i] != 0)));
      chk({playback_divisor_x2, record_divisor_x2}, {div_tab[i], div_tab[7 - i]});
    end
    for (int i = 0; i < 16; i++) begin
      v = {16'h0000, 1'b0, 7'(i * 8), i[2:0], i[3:0], 1'b0};
      xfer(1'b1, 12'h004, v, r, e);
      xfer(1'b0, 12'h004, 32'h0, r, e);
      chk(r, v);
      chk(32'(headset_pga_gain), (i == 15) ? 32'h0000_0077 : 32'(i * 8));
      chk({headset_pga_mute, headset_agc_target, agc_attack_ms, agc_decay_ms},
          {1'b0, i[2:0], att_tab[i % 4], dec_tab[i / 4]});
    end
    xfer(1'b1, 12'h004, 32'h0000_8001, r, e);
    chk(32'(agc_active), 32'h0000_0000);
    chk(32'(headset_pga_mute), 32'h0000_0001);
    headset_selected <= 1'b1;
    agc_applied_gain <= 8'hE8;
    @(posedge pclk);
    chk(32'(agc_active), 32'h0000_0001);
    xfer(1'b0, 12'h004, 32'h0, r, e);
    chk(r, 32'h0000_E801);
    xfer(1'b1, 12'h008, 32'h0000_FFFF, r, e);
    xfer(1'b0, 12'h008, 32'h0, r, e);
    chk(r, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    xfer(1'b0, 12'h000, 32'h0, r, e);
    chk(r, 32'h0000_CF38);
    finish_test();
  end
  // Cuts a hang short well beyond the under two hundred cycles the sequence needs.
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    finish_test();
  end
endmodule : test_audio_codec_format_agc_regs
`default_nettype wire
